/* File: rtl/ptmr_params.svh */
// constants and contract list for the 10-bit periodic timer
//
// Contract
// - clear-select low: period match clears, sets both flags
// - clear-select high: duty match clears, duty flag only
// - duty value zero: count to 3FF, no duty flag
// - compare output changes only on duty match or timer_on rise
// - timer_on rise loads initial level; func 00 holds
// - mode 11 counts like compare, no output
// - mode 10 func 10: period clears, duty sets width
// - period 1..1023 clocks; zero gives 1024
// - duty at or above period gives full active
// - pwm raises both flags on their matches
// - output_control picks active level; polarity inverts
// - func 00/01 force output, counting continues
// - mode 10 func 11: on rise starts pulse
// - duty match ends pulse, clears timer_on, flags
// - single pulse ignores period; clears only on rise
// - mode 01: capture edge latches counter into duty
// - capture counter free runs; period match wraps, flags
// - capture func 11 disables capture, counter runs
// - capture period zero lets counter reach maximum
// - capture ignores clear-select, control, polarity bits
// - values held as low byte plus two-bit high
// - capture edge: rise, fall, both, disabled
// - compare func: none, low, high, toggle
// - on rise clears counter; fall holds value
// - clock select: sys/4, sys, high/16, high/64, sub
`ifndef PTMR_PARAMS_SVH
`define PTMR_PARAMS_SVH
// ==========================================================
// register byte addresses
`define PTMR_ADDR_CTRL0 8'h00
`define PTMR_ADDR_CTRL1 8'h04
`define PTMR_ADDR_CNT_LO 8'h08
`define PTMR_ADDR_CNT_HI 8'h0C
`define PTMR_ADDR_DUTY_LO 8'h10
`define PTMR_ADDR_DUTY_HI 8'h14
`define PTMR_ADDR_PER_LO 8'h18
`define PTMR_ADDR_PER_HI 8'h1C
`define PTMR_ADDR_FLAGS 8'h20
// ==========================================================
// field positions
`define PTMR_C0_PAUSE 7
`define PTMR_C0_CK_HI 6
`define PTMR_C0_CK_LO 4
`define PTMR_C0_ON 3
`define PTMR_C1_MODE_HI 7
`define PTMR_C1_MODE_LO 6
`define PTMR_C1_FUNC_HI 5
`define PTMR_C1_FUNC_LO 4
`define PTMR_C1_OC 3
`define PTMR_C1_POL 2
`define PTMR_C1_CAPS 1
`define PTMR_C1_CCLR 0
`define PTMR_FL_DUTY 0
`define PTMR_FL_PER 1
// ==========================================================
// values and divider settings
`define PTMR_CNT_MAX 10'h3FF
`define PTMR_CNT_ZERO 10'h000
`define PTMR_ZERO8 8'h00
`define PTMR_ZERO32 32'h0000_0000
`define PTMR_DIV_W 6
`define PTMR_DIV4_MASK 6'h03
`define PTMR_DIV16_MASK 6'h0F
`define PTMR_DIV64_MASK 6'h3F
// sub clock has no source here; approximated as sys/64
`define PTMR_SUB_MASK 6'h3F
`define PTMR_FUNC_00 2'h0
`define PTMR_FUNC_01 2'h1
`define PTMR_FUNC_10 2'h2
`define PTMR_FUNC_11 2'h3
`endif

/* File: rtl/ptmr_pkg.sv */
// types for the 10-bit periodic timer
package ptmr_pkg;
    typedef enum logic [1:0]
    {
        PTMR_CMP = 2'b00,
        PTMR_CAP = 2'b01,
        PTMR_PWM = 2'b10,
        PTMR_TMR = 2'b11
    } ptmr_mode_e;
    typedef enum logic [1:0]
    {
        PTMR_IDLE = 2'b00,
        PTMR_ADDR = 2'b01
    } ptmr_bus_e;
endpackage

/* File: rtl/ptmr_top.sv */
// 10-bit periodic timer with ahb-lite register slave
//
// Local design decisions: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "ptmr_params.svh"
module ptmr_top
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // ahb-lite slave
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    // pins
    input wire logic i_capture_input_pin,
    output logic o_timer_out
);
// ==========================================================
// bus slave
logic [7:0] ctrl0_r;
logic [7:0] ctrl1_r;
logic [9:0] duty_capture_value_r;
logic [9:0] period_value_r;
logic [9:0] cnt_r;
logic duty_match_flag_r;
logic period_match_flag_r;
logic wr_pend_r;
logic [7:0] wr_addr_r;
logic [31:0] hrdata_r;
logic out_r;
wire addr_ok = i_hsel & i_hready & i_htrans[1];
wire [7:0] a8 = i_haddr[7:0];
wire wr_go = addr_ok & i_hwrite;
wire rd_go = addr_ok & ~i_hwrite;
wire wr_c0 = wr_pend_r & (wr_addr_r == `PTMR_ADDR_CTRL0);
wire wr_c1 = wr_pend_r & (wr_addr_r == `PTMR_ADDR_CTRL1);
wire wr_dl = wr_pend_r & (wr_addr_r == `PTMR_ADDR_DUTY_LO);
wire wr_dh = wr_pend_r & (wr_addr_r == `PTMR_ADDR_DUTY_HI);
wire wr_pl = wr_pend_r & (wr_addr_r == `PTMR_ADDR_PER_LO);
wire wr_ph = wr_pend_r & (wr_addr_r == `PTMR_ADDR_PER_HI);
wire wr_fl = wr_pend_r & (wr_addr_r == `PTMR_ADDR_FLAGS);
wire [7:0] wb = i_hwdata[7:0];
// unused high bits read as zero
wire [31:0] rd_mux =
    (a8 == `PTMR_ADDR_CTRL0) ? {24'h000000, ctrl0_r[7:3], 3'h0} :
    (a8 == `PTMR_ADDR_CTRL1) ? {24'h000000, ctrl1_r} :
    (a8 == `PTMR_ADDR_CNT_LO) ? {24'h000000, cnt_r[7:0]} :
    (a8 == `PTMR_ADDR_CNT_HI) ? {30'h00000000, cnt_r[9:8]} :
    (a8 == `PTMR_ADDR_DUTY_LO) ?
        {24'h000000, duty_capture_value_r[7:0]} :
    (a8 == `PTMR_ADDR_DUTY_HI) ?
        {30'h00000000, duty_capture_value_r[9:8]} :
    (a8 == `PTMR_ADDR_PER_LO) ? {24'h000000, period_value_r[7:0]} :
    (a8 == `PTMR_ADDR_PER_HI) ? {30'h00000000, period_value_r[9:8]} :
    (a8 == `PTMR_ADDR_FLAGS) ?
        {30'h00000000, period_match_flag_r, duty_match_flag_r} :
    `PTMR_ZERO32;
always_ff @(posedge i_clk)
begin
    if (i_sys_rst)
    begin
        wr_pend_r <= 1'b0;
        wr_addr_r <= `PTMR_ZERO8;
        hrdata_r <= `PTMR_ZERO32;
    end
    else
    begin
        wr_pend_r <= wr_go;
        if (wr_go)
            wr_addr_r <= a8;
        if (rd_go)
            hrdata_r <= rd_mux;
    end
end
assign o_hrdata = hrdata_r;
assign o_hreadyout = 1'b1;
assign o_hresp = 1'b0;
// ==========================================================
// control fields
wire timer_on = ctrl0_r[`PTMR_C0_ON];
wire counter_pause = ctrl0_r[`PTMR_C0_PAUSE];
wire [2:0] counter_clock_select =
    ctrl0_r[`PTMR_C0_CK_HI:`PTMR_C0_CK_LO];
ptmr_pkg::ptmr_mode_e mode;
assign mode = ptmr_pkg::ptmr_mode_e'(
    ctrl1_r[`PTMR_C1_MODE_HI:`PTMR_C1_MODE_LO]);
wire [1:0] func = ctrl1_r[`PTMR_C1_FUNC_HI:`PTMR_C1_FUNC_LO];
wire output_control = ctrl1_r[`PTMR_C1_OC];
wire output_polarity = ctrl1_r[`PTMR_C1_POL];
wire counter_clear_select = ctrl1_r[`PTMR_C1_CCLR];
// ==========================================================
// timer clock enable
logic [`PTMR_DIV_W-1:0] div_r;
logic on_d_r;
wire [`PTMR_DIV_W-1:0] div_mask =
    (counter_clock_select == 3'h0) ? `PTMR_DIV4_MASK :
    (counter_clock_select == 3'h2) ? `PTMR_DIV16_MASK :
    (counter_clock_select == 3'h3) ? `PTMR_DIV64_MASK :
    `PTMR_SUB_MASK;
// undefined codes 101 to 111 fall back to the sub clock rate
wire tick = (counter_clock_select == 3'h1) |
    ((div_r & div_mask) == div_mask);
// ==========================================================
// capture input sync and edge detection
logic cap_s1_r;
logic cap_s2_r;
logic cap_s3_r;
wire cap_rise = cap_s2_r & ~cap_s3_r;
wire cap_fall = ~cap_s2_r & cap_s3_r;
wire cap_edge = (func == `PTMR_FUNC_00) ? cap_rise :
    (func == `PTMR_FUNC_01) ? cap_fall :
    (func == `PTMR_FUNC_10) ? (cap_rise | cap_fall) :
    1'b0;
// ==========================================================
// comparators
wire on_rise = timer_on & ~on_d_r;
wire run = timer_on & ~counter_pause & tick & ~on_rise;
wire is_pwm = (mode == ptmr_pkg::PTMR_PWM);
wire single = is_pwm & (func == `PTMR_FUNC_11);
wire is_cap = (mode == ptmr_pkg::PTMR_CAP);
wire is_cmp = (mode == ptmr_pkg::PTMR_CMP) |
    (mode == ptmr_pkg::PTMR_TMR);
wire [9:0] cnt_inc = cnt_r + 10'h001;
// matches are taken on the count about to be reached
// duty zero never matches: counter overflows instead
wire duty_hit = run & (duty_capture_value_r != `PTMR_CNT_ZERO) &
    (cnt_inc == duty_capture_value_r);
// period zero wraps at 3FF
wire per_hit = run & ((period_value_r == `PTMR_CNT_ZERO) ?
    (cnt_r == `PTMR_CNT_MAX) : (cnt_inc == period_value_r));
// single pulse ignores period and clear select
wire clr_sel_duty = is_cmp & counter_clear_select;
wire per_clr = per_hit & ~single & ~clr_sel_duty;
wire duty_clr = duty_hit & clr_sel_duty;
wire set_duty = duty_hit & ~is_cap;
wire set_per = per_hit & ~single & ~clr_sel_duty;
wire capture = is_cap & timer_on & cap_edge;
// counter reaching duty in single pulse ends the pulse
wire sp_end = single & duty_hit;
wire [9:0] cnt_nxt = on_rise ? `PTMR_CNT_ZERO :
    (per_clr | duty_clr) ? `PTMR_CNT_ZERO :
    run ? cnt_inc : cnt_r;
// ==========================================================
// output generation
wire pwm_active = (duty_capture_value_r >= period_value_r) &
    (period_value_r != `PTMR_CNT_ZERO) ? 1'b1 :
    (cnt_r < duty_capture_value_r);
wire pwm_lvl = (func == `PTMR_FUNC_00) ? 1'b0 :
    (func == `PTMR_FUNC_01) ? 1'b1 : pwm_active;
// active level and final inversion
wire pwm_pin = (pwm_lvl ~^ output_control) ^ output_polarity;
wire sp_pin = (timer_on & ~sp_end) ~^ output_control;
logic cmp_lvl_r;
wire cmp_nxt = on_rise ? output_control :
    ~(set_duty & (mode == ptmr_pkg::PTMR_CMP)) ? cmp_lvl_r :
    (func == `PTMR_FUNC_01) ? 1'b0 :
    (func == `PTMR_FUNC_10) ? 1'b1 :
    (func == `PTMR_FUNC_11) ? ~cmp_lvl_r : cmp_lvl_r;
wire out_nxt = (mode == ptmr_pkg::PTMR_CMP) ?
        (cmp_nxt ^ output_polarity) :
    single ? (sp_pin ^ output_polarity) :
    is_pwm ? pwm_pin : 1'b0;
// ==========================================================
// state registers
always_ff @(posedge i_clk)
begin
    if (i_sys_rst)
    begin
        ctrl0_r <= `PTMR_ZERO8;
        ctrl1_r <= `PTMR_ZERO8;
        duty_capture_value_r <= `PTMR_CNT_ZERO;
        period_value_r <= `PTMR_CNT_ZERO;
        cnt_r <= `PTMR_CNT_ZERO;
        div_r <= '0;
        on_d_r <= 1'b0;
        cap_s1_r <= 1'b0;
        cap_s2_r <= 1'b0;
        cap_s3_r <= 1'b0;
        cmp_lvl_r <= 1'b0;
        out_r <= 1'b0;
        duty_match_flag_r <= 1'b0;
        period_match_flag_r <= 1'b0;
    end
    else
    begin
        div_r <= div_r + 1'b1;
        on_d_r <= timer_on;
        cap_s1_r <= i_capture_input_pin;
        cap_s2_r <= cap_s1_r;
        cap_s3_r <= cap_s2_r;
        cnt_r <= cnt_nxt;
        cmp_lvl_r <= cmp_nxt;
        out_r <= out_nxt;
        if (wr_c0)
            ctrl0_r <= {wb[7:3], 3'h0};
        else if (sp_end)
            ctrl0_r[`PTMR_C0_ON] <= 1'b0;
        if (wr_c1)
            ctrl1_r <= wb;
        if (capture)
            duty_capture_value_r <= cnt_r;
        else if (wr_dl)
            duty_capture_value_r[7:0] <= wb;
        else if (wr_dh)
            duty_capture_value_r[9:8] <= wb[1:0];
        if (wr_pl)
            period_value_r[7:0] <= wb;
        else if (wr_ph)
            period_value_r[9:8] <= wb[1:0];
        // sticky; write one clears, hardware set wins
        duty_match_flag_r <= (set_duty | capture) |
            (duty_match_flag_r & ~(wr_fl & wb[`PTMR_FL_DUTY]));
        period_match_flag_r <= set_per |
            (period_match_flag_r & ~(wr_fl & wb[`PTMR_FL_PER]));
    end
end
assign o_timer_out = out_r;
endmodule
`default_nettype wire

/* File: verification/ptmr_pin_src.sv */
// capture-pin source standing in for the external signal
`timescale 1ns/100ps
`default_nettype none
module ptmr_pin_src
(
    // clock and request
    input wire logic i_clk,
    input wire logic i_go,
    // pin
    output logic o_pin
);
    logic [2:0] div_r;
    // ====================
    // slow square wave: each level lasts four clocks so the
    // two-flop synchroniser never misses an edge
    always_ff @(posedge i_clk)
    begin
        div_r <= i_go ? div_r + 3'h1 : 3'h0;
        o_pin <= i_go & div_r[2];
    end
endmodule
`default_nettype wire

/* File: verification/ptmr_assertions.sv */
// bus-port assertions for the periodic timer
`timescale 1ns/100ps
`default_nettype none
module ptmr_assertions
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // bus
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic i_hready,
    input wire logic [31:0] o_hrdata,
    input wire logic o_hreadyout,
    input wire logic o_hresp
);
    // ====================
    // read address phase at one byte address
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    sequence rd_at(logic [7:0] a);
        i_hsel && i_hready && i_htrans[1] && !i_hwrite && i_haddr[7:0] == a;
    endsequence
    chk_ready_high: assert property (o_hreadyout)
        else $error("slave stalled");
    chk_resp_okay: assert property (!o_hresp)
        else $error("error response");
    chk_duty_lo_w:
    assert property (rd_at(8'h10) |=> o_hrdata[31:8] == 24'h0)
        else $error("duty low read too wide");
    chk_duty_hi_w:
    assert property (rd_at(8'h14) |=> o_hrdata[31:2] == 30'h0)
        else $error("duty high unused bits set");
    chk_per_hi_w:
    assert property (rd_at(8'h1C) |=> o_hrdata[31:2] == 30'h0)
        else $error("period high unused bits set");
    chk_flags_w:
    assert property (rd_at(8'h20) |=> o_hrdata[31:2] == 30'h0)
        else $error("flag read too wide");
    chk_unmapped_zero:
    assert property (rd_at(8'h40) |=> o_hrdata == 32'h0)
        else $error("unmapped read not zero");
    chk_rdata_holds:
    assert property (!(i_hsel && i_hready && i_htrans[1] && !i_hwrite)
        |=> $stable(o_hrdata)) else $error("read data moved");
endmodule
bind ptmr_top ptmr_assertions u_chk
(
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_hsel(i_hsel),
    .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
    .i_hready(i_hready), .o_hrdata(o_hrdata),
    .o_hreadyout(o_hreadyout), .o_hresp(o_hresp)
);
`default_nettype wire

/* File: verification/periodic_timer_modes_10bit_tb_top.sv */
// directed bench for the periodic timer over its bus and pins
`timescale 1ns/100ps
`default_nettype none
module periodic_timer_modes_10bit_tb_top;
    logic i_clk = 1'b0, rst = 1'b1, hwrite = 1'b0, go = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic hready, hresp, pin, t_out;
    int err_total = 0, n_checks = 0, cyc = 0;
    // compare- and timer-mode control bytes and the level each settles to
    logic [7:0] cc[5] = '{8'h08, 8'h18, 8'h20, 8'h00, 8'hC8};
    logic [4:0] ce = 5'b00101;
    // control byte 0 that starts each run: clock select plus timer_on
    logic [7:0] on_c0 = 8'h18;
    ptmr_top dut
    (
        .i_clk(i_clk), .i_sys_rst(rst), .i_hsel(1'b1),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
        .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .i_capture_input_pin(pin), .o_timer_out(t_out)
    );
    ptmr_pin_src u_pin(.i_clk(i_clk), .i_go(go), .o_pin(pin));
    // ====================
    // clock and hang guard
    initial
    begin
        forever #5 i_clk = ~i_clk;
    end
    always @(posedge i_clk)
    begin
        cyc = cyc + 1;
        err_total += (cyc == 20000);
        if (cyc == 20000)
            report_and_stop();
    end
    // ====================
    // bus and check tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks += 1;
        err_total += (seen !== exp);
        if (seen !== exp)
            $display("ERROR %0t: saw %h want %h", $time, seen, exp);
    endtask
    // one single transfer; read data lands in rd
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge i_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge i_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    // timer is stopped before setup, as mode changes need
    task automatic run(input logic [7:0] c1, input logic [9:0] d,
        input logic [9:0] p);
        xfer(1, 8'h00, 32'h10);
        xfer(1, 8'h04, {24'h0, c1});
        xfer(1, 8'h10, {24'h0, d[7:0]});
        xfer(1, 8'h14, {30'h0, d[9:8]});
        xfer(1, 8'h18, {24'h0, p[7:0]});
        xfer(1, 8'h1C, {30'h0, p[9:8]});
        xfer(1, 8'h20, 32'h3);
        xfer(1, 8'h00, {24'h0, on_c0});
    endtask
    task automatic flags_are(input logic [31:0] e);
        xfer(1, 8'h00, 32'h10);
        xfer(0, 8'h20, 32'h0);
        chk(rd, e);
    endtask
    // whole periods only, so the high count is phase free
    task automatic pwm_hi(input logic [7:0] c1, input logic [9:0] d,
        input logic [9:0] p, input int n, input int e);
        int h = 0;
        run(c1, d, p);
        repeat (20) @(posedge i_clk);
        repeat (n)
        begin
            @(posedge i_clk);
            h += (t_out === 1'b1);
        end
        chk(h, e);
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ====================
    // main sequence
    initial
    begin
        repeat (16) @(posedge i_clk);
        rst <= 1'b0;
        for (int a = 16; a < 32; a += 4)
        begin
            xfer(0, a[7:0], 32'h0);
            chk(rd, 32'h0);
        end
        xfer(1, 8'h14, 32'hFF);
        xfer(0, 8'h14, 32'h0);
        chk(rd, 32'h3);
        xfer(0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        run(8'h30, 10'd3, 10'd5);
        repeat (40) @(posedge i_clk);
        flags_are(32'h3);
        xfer(1, 8'h20, 32'h3);
        xfer(0, 8'h20, 32'h0);
        chk(rd, 32'h0);
        run(8'h31, 10'd3, 10'd2);
        repeat (40) @(posedge i_clk);
        flags_are(32'h1);
        run(8'h01, 10'd0, 10'd0);
        repeat (1100) @(posedge i_clk);
        flags_are(32'h0);
        for (int i = 0; i < 5; i++)
        begin
            run(cc[i], 10'd3, 10'd5);
            repeat (40) @(posedge i_clk);
            chk({31'h0, t_out}, {31'h0, ce[i]});
        end
        pwm_hi(8'hA8, 10'd2, 10'd8, 80, 20);
        flags_are(32'h3);
        pwm_hi(8'hAC, 10'd2, 10'd8, 80, 60);
        pwm_hi(8'hA8, 10'd9, 10'd8, 80, 80);
        pwm_hi(8'h98, 10'd2, 10'd8, 80, 80);
        pwm_hi(8'h88, 10'd2, 10'd8, 80, 0);
        pwm_hi(8'hA8, 10'd256, 10'd0, 1024, 256);
        // toggle on every duty match: half the time high
        pwm_hi(8'h38, 10'd3, 10'd5, 80, 40);
        // timer clock at a quarter rate stretches the period to 32
        on_c0 = 8'h08;
        pwm_hi(8'hA8, 10'd2, 10'd8, 64, 16);
        on_c0 = 8'h18;
        // software keeps func 11 and timer_on during the pulse
        run(8'hB8, 10'd10, 10'd0);
        repeat (3) @(posedge i_clk);
        chk({31'h0, t_out}, 32'h1);
        repeat (30) @(posedge i_clk);
        chk({31'h0, t_out}, 32'h0);
        xfer(0, 8'h00, 32'h0);
        chk(rd, 32'h10);
        flags_are(32'h1);
        for (int i = 0; i < 4; i++)
        begin
            run(8'h40 + 8'(i * 16), 10'd0, 10'd0);
            go <= 1'b1;
            repeat (40) @(posedge i_clk);
            go <= 1'b0;
            flags_are({31'h0, i != 3});
        end
        // no pin activity: only the period match wraps and flags
        run(8'h40, 10'd0, 10'd5);
        repeat (40) @(posedge i_clk);
        flags_are(32'h2);
        report_and_stop();
    end
endmodule
`default_nettype wire
